/* design/imc_pkg.sv */
// constants, phases and timing counts for the isa master cycle sequencer
// Functional notes
// R1 - every spacing is counted in whole periods T of the bus timing clock.
// R2 - read data is sampled no sooner than 4 T (16-bit) or 10 T (8-bit) after the address latch.
// R3 - address and byte-high enable are valid 6 T (16-bit) or 12 T (8-bit) before ready may drop.
// R4 - read data is taken no sooner than 4 T (16-bit) or 10 T (8-bit) after the address is valid.
// R5 - a slave wanting waits drops ready within 2 T (16-bit) or 5 T (8-bit) of the command.
// R6 - read data is sampled no sooner than 2 T (16-bit) or 5 T (8-bit) after the read command.
// R7 - after ready returns high, reads sample 1 T later at the earliest and writes end 2 T later.
// R8 - a write command stays asserted at least 1 T after ready is seen high.
// R9 - refresh read strobes drop no earlier than 1 T after ready is high.
// R10 - the next address latch comes at least 2 T after ready is high.
// R11 - address and byte-high enable stay valid at least 2 T after ready is high.
// R12 - the slave keeps read data valid until the read command drops.
// R13 - the slave floats the data bus no earlier than the read command drops.
// R14 - memory write data is driven at least 2 T before the memory write command.
// R15 - i/o write data is driven at least 2 T before the i/o write command.
// R16 - write data is held at least 1 T after the write command drops.
// R17 - the copied byte of an odd 8-bit write is held 1 T after the command, then floated.
package imc_pkg;

  // ----------------------------------------------------------------
  // clock and bus period
  // ----------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int T_NS = 25;
  localparam int CYC_PER_T = (T_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // spacings in T, then in clock cycles
  // ----------------------------------------------------------------
  localparam int ADDR_DATA16_T = 4;
  localparam int ADDR_DATA8_T = 10;
  localparam int ADDR_RDYNEG16_T = 6;
  localparam int ADDR_RDYNEG8_T = 12;
  localparam int CMD_RDYNEG16_T = 2;
  localparam int CMD_RDYNEG8_T = 5;
  localparam int RDY_READ_T = 1;
  localparam int RDY_WRITE_T = 2;
  localparam int RDY_WR_NEG_T = 1;
  localparam int RDY_REFR_NEG_T = 1;
  localparam int RDY_NEXT_ALE_T = 2;
  localparam int RDY_ADDR_HOLD_T = 2;
  localparam int WDATA_SETUP_T = 2;
  localparam int WDATA_HOLD_T = 1;

  localparam int ADDR_DATA16_CYC = ADDR_DATA16_T * CYC_PER_T;
  localparam int ADDR_DATA8_CYC = ADDR_DATA8_T * CYC_PER_T;
  localparam int CMD_DATA16_CYC = CMD_RDYNEG16_T * CYC_PER_T;
  localparam int CMD_DATA8_CYC = CMD_RDYNEG8_T * CYC_PER_T;
  // command placed so the latest ready-drop point sees the address long enough
  localparam int CMD_DLY16_CYC = (ADDR_RDYNEG16_T - CMD_RDYNEG16_T) * CYC_PER_T;
  localparam int CMD_DLY8_CYC = (ADDR_RDYNEG8_T - CMD_RDYNEG8_T) * CYC_PER_T;
  localparam int RDY_READ_CYC = RDY_READ_T * CYC_PER_T;
  localparam int RDY_WRITE_CYC = RDY_WRITE_T * CYC_PER_T;
  localparam int RDY_WR_NEG_CYC = RDY_WR_NEG_T * CYC_PER_T;
  localparam int RDY_REFR_CYC = RDY_REFR_NEG_T * CYC_PER_T;
  localparam int END_HOLD_CYC = RDY_ADDR_HOLD_T * CYC_PER_T;
  localparam int WDATA_SETUP_CYC = WDATA_SETUP_T * CYC_PER_T;
  localparam int WDATA_HOLD_CYC = WDATA_HOLD_T * CYC_PER_T;

  // ----------------------------------------------------------------
  // widths, reset values and phases
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam int CNT_W = 5;
  localparam int CNT_MAX = 31;
  localparam int RDY_MAX = 3;
  localparam logic STROBE_OFF = 1'h1;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_CMD,
    PH_END
  } imc_phase_t;

endpackage

/* design/imc_fifo.sv */
// shift-register fifo holding read data until the user takes it
`timescale 1ns/1ps
module imc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int CW = $clog2(DEPTH + 1);

  // head sits in mem[0] so the output is a plain flop
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0] cnt;
    logic room;
    logic nempty;
  } imc_fifo_state_t;

  imc_fifo_state_t s;
  imc_fifo_state_t next_s;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic pop;
    logic push;
    logic [CW-1:0] left;
    next_s = s;
    pop = s.nempty && out_ready_i;
    push = in_valid_i && s.room;
    left = s.cnt - CW'(pop);
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_s.mem[i] = s.mem[i+1];
      end
    end
    if (push) begin
      next_s.mem[left] = in_data_i;
    end
    next_s.cnt = left + CW'(push);
    next_s.room = (next_s.cnt != CW'(DEPTH));
    next_s.nempty = (next_s.cnt != '0);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '{room: 1'h1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign in_ready_o = s.room;
  assign out_valid_o = s.nempty;
  assign out_data_o = s.mem[0];

endmodule

/* design/imc_seq.sv */
// isa bus master cycle sequencer with read data fifo
`timescale 1ns/1ps
module imc_seq #(
  parameter int FIFO_DEPTH = imc_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic req_io_i,
  input wire logic req_low_i,
  input wire logic req_wide_i,
  input wire logic req_refresh_i,
  input wire logic req_sbhe_i,
  input wire logic [imc_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [imc_pkg::DATA_W-1:0] req_wdata_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [imc_pkg::DATA_W-1:0] rd_data_o,
  output logic ale_o,
  output logic [imc_pkg::ADDR_W-1:0] sa_o,
  output logic sbhe_n_o,
  output logic memr_n_o,
  output logic memw_n_o,
  output logic smemr_n_o,
  output logic smemw_n_o,
  output logic ior_n_o,
  output logic iow_n_o,
  output logic [imc_pkg::DATA_W-1:0] sd_o,
  output logic sd_oe_o,
  input wire logic [imc_pkg::DATA_W-1:0] sd_i,
  input wire logic iochrdy_i
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    imc_pkg::imc_phase_t st;
    logic ready;
    logic ale;
    logic [imc_pkg::ADDR_W-1:0] sa;
    logic sbhe_n;
    logic memr_n;
    logic memw_n;
    logic smemr_n;
    logic smemw_n;
    logic ior_n;
    logic iow_n;
    logic [imc_pkg::DATA_W-1:0] sd;
    logic sd_oe;
    logic write;
    logic io;
    logic low;
    logic wide;
    logic refresh;
    logic [imc_pkg::CNT_W-1:0] t_addr;
    logic [imc_pkg::CNT_W-1:0] t_cmd;
    logic [1:0] t_rdy;
    logic [imc_pkg::CNT_W-1:0] t_end;
    logic push;
    logic [imc_pkg::DATA_W-1:0] pdata;
  } imc_seq_state_t;

  localparam imc_seq_state_t RST_S = '{
    st: imc_pkg::PH_IDLE,
    sbhe_n: imc_pkg::STROBE_OFF,
    memr_n: imc_pkg::STROBE_OFF,
    memw_n: imc_pkg::STROBE_OFF,
    smemr_n: imc_pkg::STROBE_OFF,
    smemw_n: imc_pkg::STROBE_OFF,
    ior_n: imc_pkg::STROBE_OFF,
    iow_n: imc_pkg::STROBE_OFF,
    default: '0
  };

  imc_seq_state_t s;
  imc_seq_state_t next_s;
  logic fifo_room;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true once cnt+1 whole cycles have passed, i.e. the limit is met
  function automatic logic reached(input logic [imc_pkg::CNT_W-1:0] cnt, input int n);
    return (int'(cnt) + 1) >= n;
  endfunction

  // saturating count so long wait states never wrap a timer
  function automatic logic [imc_pkg::CNT_W-1:0] bump(input logic [imc_pkg::CNT_W-1:0] cnt);
    return (int'(cnt) == imc_pkg::CNT_MAX) ? cnt : cnt + 5'h01;
  endfunction

  function automatic int cmd_dly(input logic wide);
    return wide ? imc_pkg::CMD_DLY16_CYC : imc_pkg::CMD_DLY8_CYC;
  endfunction

  function automatic int cmd_data(input logic wide);
    return wide ? imc_pkg::CMD_DATA16_CYC : imc_pkg::CMD_DATA8_CYC;
  endfunction

  function automatic int addr_data(input logic wide);
    return wide ? imc_pkg::ADDR_DATA16_CYC : imc_pkg::ADDR_DATA8_CYC;
  endfunction

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  // one cycle per bus period T; all spacing is counted by t_* timers
  always_comb begin
    logic spaced;
    logic done;
    // both flags are settled below; zero keeps them defined on every path
    spaced = 1'h0;
    done = 1'h0;
    next_s = s;
    next_s.ale = 1'h0;
    next_s.push = 1'h0;
    // prior cycles of ready high, current cycle excluded
    next_s.t_rdy = iochrdy_i ? ((s.t_rdy == 2'h3) ? s.t_rdy : s.t_rdy + 2'h1) : 2'h0;
    // never finish before the slave's wait window closes
    spaced = reached(s.t_cmd, cmd_data(s.wide)) // see R5, R6
      && reached(s.t_addr, addr_data(s.wide)); // see R2, R4
    if (s.refresh) begin
      done = spaced && iochrdy_i && int'(s.t_rdy) >= imc_pkg::RDY_REFR_CYC; // see R9
    end else if (s.write) begin
      done = spaced && iochrdy_i && int'(s.t_rdy) >= imc_pkg::RDY_WRITE_CYC // see R7
        && int'(s.t_rdy) >= imc_pkg::RDY_WR_NEG_CYC; // see R8
    end else begin
      done = spaced && iochrdy_i && int'(s.t_rdy) >= imc_pkg::RDY_READ_CYC; // see R7
    end
    unique case (s.st)
      imc_pkg::PH_IDLE: begin
        if (req_valid_i && s.ready) begin
          // address, byte-high and write data all go out with the latch
          next_s.st = imc_pkg::PH_ADDR;
          next_s.ale = 1'h1;
          next_s.sa = req_addr_i;
          next_s.sbhe_n = !req_sbhe_i;
          next_s.write = req_write_i && !req_refresh_i;
          next_s.io = req_io_i;
          next_s.low = req_low_i;
          next_s.wide = req_wide_i;
          next_s.refresh = req_refresh_i;
          next_s.t_addr = '0;
          // odd byte to a narrow slave is copied onto the low lane
          if (!req_wide_i && req_addr_i[0]) begin
            next_s.sd = {req_wdata_i[15:8], req_wdata_i[15:8]}; // see R17
          end else begin
            next_s.sd = req_wdata_i;
          end
          next_s.sd_oe = req_write_i && !req_refresh_i; // see R14, R15
        end
      end
      imc_pkg::PH_ADDR: begin
        next_s.t_addr = bump(s.t_addr);
        // command waits for data setup and the address-to-ready spacing
        if (int'(s.t_addr) + 1 == cmd_dly(s.wide)) begin // see R3, R14, R15
          next_s.st = imc_pkg::PH_CMD;
          next_s.t_cmd = '0;
          if (s.refresh) begin
            next_s.memr_n = 1'h0;
            next_s.smemr_n = 1'h0;
          end else if (s.io) begin
            next_s.ior_n = s.write;
            next_s.iow_n = !s.write;
          end else begin
            next_s.memr_n = s.write;
            next_s.memw_n = !s.write;
            next_s.smemr_n = s.write || !s.low;
            next_s.smemw_n = !s.write || !s.low;
          end
        end
      end
      imc_pkg::PH_CMD: begin
        next_s.t_addr = bump(s.t_addr);
        next_s.t_cmd = bump(s.t_cmd);
        if (done) begin
          // data is caught on the edge the read command drops, still valid
          next_s.push = !s.write && !s.refresh; // see R12, R13
          next_s.pdata = sd_i;
          next_s.memr_n = imc_pkg::STROBE_OFF;
          next_s.memw_n = imc_pkg::STROBE_OFF;
          next_s.smemr_n = imc_pkg::STROBE_OFF;
          next_s.smemw_n = imc_pkg::STROBE_OFF;
          next_s.ior_n = imc_pkg::STROBE_OFF;
          next_s.iow_n = imc_pkg::STROBE_OFF;
          next_s.st = imc_pkg::PH_END;
          next_s.t_end = '0;
        end
      end
      imc_pkg::PH_END: begin
        next_s.t_end = bump(s.t_end);
        // address and data held here; the latch cannot fire until idle
        if (int'(s.t_end) + 1 == imc_pkg::END_HOLD_CYC) begin // see R10, R11
          next_s.st = imc_pkg::PH_IDLE;
          next_s.sd_oe = 1'h0; // see R16, R17
        end
      end
    endcase
    // fifo only drains, so a room check now still holds at the sample
    next_s.ready = (next_s.st == imc_pkg::PH_IDLE) && fifo_room
      && !(s.st == imc_pkg::PH_IDLE && req_valid_i && s.ready);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= RST_S;
    end else begin
      s <= next_s; // see R1
    end
  end

  // ----------------------------------------------------------------
  // read data buffer
  // ----------------------------------------------------------------
  imc_fifo #(
    .WIDTH(imc_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(s.push),
    .in_ready_o(fifo_room),
    .in_data_i(s.pdata),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(rd_data_o)
  );

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  assign req_ready_o = s.ready;
  assign ale_o = s.ale;
  assign sa_o = s.sa;
  assign sbhe_n_o = s.sbhe_n;
  assign memr_n_o = s.memr_n;
  assign memw_n_o = s.memw_n;
  assign smemr_n_o = s.smemr_n;
  assign smemw_n_o = s.smemw_n;
  assign ior_n_o = s.ior_n;
  assign iow_n_o = s.iow_n;
  assign sd_o = s.sd;
  assign sd_oe_o = s.sd_oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic rd_act;
  logic wr_act;
  logic cmd_act;
  logic [imc_pkg::CNT_W-1:0] ale_age;
  logic [imc_pkg::CNT_W-1:0] rd_age;

  assign rd_act = !memr_n_o || !smemr_n_o || !ior_n_o;
  assign wr_act = !memw_n_o || !smemw_n_o || !iow_n_o;
  assign cmd_act = rd_act || wr_act;

  // cycles since the latch and cycles a read command has been low
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ale_age <= '0;
      rd_age <= '0;
    end else begin
      ale_age <= ale_o ? 5'h01 : bump(ale_age);
      rd_age <= rd_act ? bump(rd_age) : 5'h00;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence cmd_end_s;
    $fell(cmd_act);
  endsequence

  sequence hold_two_s;
    $stable(sa_o) && $stable(sbhe_n_o) ##1 $stable(sa_o) && $stable(sbhe_n_o);
  endsequence

  ale_to_data_a: assert property ( // see R2, R4
    s.push |-> int'(ale_age) >= addr_data(s.wide))
    else $error("read data sampled too soon after the latch");

  strobe_place_a: assert property ( // see R3
    $rose(cmd_act) |-> int'(ale_age) == cmd_dly(s.wide))
    else $error("command not placed at the address spacing");

  cmd_to_data_a: assert property ( // see R6
    s.push |-> int'(rd_age) >= cmd_data(s.wide))
    else $error("read data sampled too soon after the command");

  rdy_to_read_a: assert property ( // see R7
    s.push |-> $past(iochrdy_i, 1) && $past(iochrdy_i, 2))
    else $error("read sampled without ready high one period");

  write_end_a: assert property ( // see R8
    $fell(wr_act) |-> $past(iochrdy_i, 1) && $past(iochrdy_i, 2) && $past(iochrdy_i, 3))
    else $error("write command dropped too soon after ready");

  refresh_end_a: assert property ( // see R9
    $fell(rd_act) && s.refresh |-> $past(iochrdy_i, 1) && $past(iochrdy_i, 2))
    else $error("refresh strobe dropped too soon after ready");

  next_ale_a: assert property ( // see R10
    cmd_end_s |-> !ale_o [*3])
    else $error("next latch too soon after ready");

  addr_hold_a: assert property ( // see R11
    cmd_end_s |-> hold_two_s)
    else $error("address changed too soon after ready");

  wdata_setup_a: assert property ( // see R14, R15
    $rose(wr_act) |-> sd_oe_o && $past(sd_oe_o, 2) && $stable(sd_o))
    else $error("write data not set up before the command");

  wdata_hold_a: assert property ( // see R16, R17
    $fell(wr_act) |-> sd_oe_o && $stable(sd_o) ##1 sd_oe_o ##1 !sd_oe_o)
    else $error("write data not held then floated");

  // inside the command window: data caught, strobes paired, bus held still
  read_catch_a: assert property ( // see R12, R13
    s.push |-> $fell(rd_act))
    else $error("read data not caught while the command was low");

  refresh_pair_a: assert property ( // see R9
    s.refresh && cmd_act |-> !memr_n_o && !smemr_n_o && !wr_act && ior_n_o)
    else $error("refresh strobes not paired");

  wdata_steady_a: assert property ( // see R14, R16
    wr_act |-> sd_oe_o && $stable(sd_o))
    else $error("write data moved under the command");

  addr_steady_a: assert property ( // see R3, R11
    cmd_act |-> $stable(sa_o) && $stable(sbhe_n_o))
    else $error("address moved under the command");

endmodule

/* tb/imc_slave.sv */
// behavioural isa slave answering the sequencer's bus cycles
`timescale 1ns/1ps
module imc_slave (
  input wire logic clk_i,
  input wire logic [imc_pkg::ADDR_W-1:0] sa_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic oe_i,
  input wire logic [imc_pkg::DATA_W-1:0] wdata_i,
  input wire logic [3:0] waits_i,
  output logic [imc_pkg::DATA_W-1:0] sd_o,
  output logic rdy_o,
  output logic [imc_pkg::DATA_W-1:0] wr_seen_o
);
  logic busy = 1'b0;
  logic [3:0] cnt = 4'h0;

  initial begin
    rdy_o = 1'b1;
    sd_o = 16'h0000;
    wr_seen_o = 16'h0000;
  end

  // ready drops one cycle after the command, inside the limit of wide slaves
  always @(posedge clk_i) begin
    busy <= !(rd_n_i && wr_n_i);
    if (!(rd_n_i && wr_n_i) && !busy && waits_i != 4'h0) begin
      rdy_o <= 1'b0;
      cnt <= waits_i;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      rdy_o <= (cnt == 4'h1);
    end
    // no pull-up on the data lines: released lines toggle, never hold
    if (!rd_n_i) begin
      sd_o <= sa_i[15:0] ^ 16'h5a5a;
    end else begin
      sd_o <= ~sd_o;
    end
    // undriven write data shows as unknown so a late enable is caught
    if (!wr_n_i) begin
      wr_seen_o <= oe_i ? wdata_i : 16'hxxxx;
    end
  end
endmodule

/* tb/imc_seq_tb.sv */
// self-checking bench for the isa master cycle sequencer
`timescale 1ns/1ps
module imc_seq_tb;
  logic clk_i, reset_n_i, req_valid_i, req_write_i, req_io_i, req_low_i, req_wide_i;
  logic req_refresh_i, req_sbhe_i, rd_ready_i, iochrdy_i, req_ready_o, rd_valid_o, ale_o;
  logic sbhe_n_o, memr_n_o, memw_n_o, smemr_n_o, smemw_n_o, ior_n_o, iow_n_o, sd_oe_o;
  logic [imc_pkg::ADDR_W-1:0] req_addr_i, sa_o, sa_end;
  logic [imc_pkg::DATA_W-1:0] req_wdata_i, rd_data_o, sd_o, sd_i, wr_seen;
  logic [3:0] waits;
  logic [5:0] strb, prev_strb = 6'h3f;
  logic prev_rdy = 1'b1;
  logic prev_oe = 1'b0;
  logic sbhe_seen;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int t_ale, t_fall, t_rise, t_rdy, t_oe, t_oe_off, n_done;
  int ale_gap = 1000;
  wire logic [5:0] strb_w = {memr_n_o, memw_n_o, smemr_n_o, smemw_n_o, ior_n_o, iow_n_o};
  wire logic rd_n = memr_n_o & smemr_n_o & ior_n_o;
  wire logic wr_n = memw_n_o & smemw_n_o & iow_n_o;

  imc_seq dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_write_i(req_write_i), .req_io_i(req_io_i),
    .req_low_i(req_low_i), .req_wide_i(req_wide_i), .req_refresh_i(req_refresh_i),
    .req_sbhe_i(req_sbhe_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .ale_o(ale_o),
    .sa_o(sa_o), .sbhe_n_o(sbhe_n_o), .memr_n_o(memr_n_o), .memw_n_o(memw_n_o),
    .smemr_n_o(smemr_n_o), .smemw_n_o(smemw_n_o), .ior_n_o(ior_n_o), .iow_n_o(iow_n_o),
    .sd_o(sd_o), .sd_oe_o(sd_oe_o), .sd_i(sd_i), .iochrdy_i(iochrdy_i));

  imc_slave slave_u (.clk_i(clk_i), .sa_i(sa_o), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .oe_i(sd_oe_o), .wdata_i(sd_o), .waits_i(waits), .sd_o(sd_i), .rdy_o(iochrdy_i),
    .wr_seen_o(wr_seen));

  // 40 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // --------------------------------
  // bus event timestamps, in edges
  // --------------------------------
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    prev_strb <= strb_w;
    prev_rdy <= iochrdy_i;
    prev_oe <= sd_oe_o;
    // keep the shortest ready-to-latch spacing seen so far
    if (ale_o && cyc - t_rdy < ale_gap) ale_gap <= cyc - t_rdy;
    if (ale_o) t_ale <= cyc;
    if (&prev_strb && !(&strb_w)) begin
      t_fall <= cyc;
      strb <= strb_w;
      sbhe_seen <= sbhe_n_o;
    end
    if (!(&prev_strb) && &strb_w) begin
      t_rise <= cyc;
      sa_end <= sa_o;
      n_done <= n_done + 1;
    end
    if (iochrdy_i && !prev_rdy) t_rdy <= cyc;
    if (sd_oe_o && !prev_oe) t_oe <= cyc;
    if (!sd_oe_o && prev_oe) t_oe_off <= cyc;
    // the whole run needs about a thousand edges; a hang ends here
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // kind is {write, io, low, wide, refresh, sbhe}; held until the take edge
  task automatic do_req(input logic [5:0] kind, input logic [19:0] addr, input logic [15:0] wd);
    @(posedge clk_i);
    {req_write_i, req_io_i, req_low_i, req_wide_i, req_refresh_i, req_sbhe_i} <= kind;
    req_addr_i <= addr;
    req_wdata_i <= wd;
    req_valid_i <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_i);
      if (req_ready_o === 1'b1) break;
    end
    chk("request taken", req_ready_o, 1);
    req_valid_i <= 1'b0;
  endtask

  // one extra edge first so the head after a previous take is visible
  task automatic pop(input logic [15:0] exp);
    @(posedge clk_i);
    for (int i = 0; i < 50 && rd_valid_o !== 1'b1; i++) @(posedge clk_i);
    chk("read valid", rd_valid_o, 1);
    chk("read data", rd_data_o, exp);
    rd_ready_i <= 1'b1;
    @(posedge clk_i);
    rd_ready_i <= 1'b0;
  endtask

  task automatic run_cyc(input logic [5:0] kind, input logic [19:0] addr, input logic [15:0] wd);
    int n0;
    logic w;
    logic [5:0] exp_s;
    n0 = n_done;
    w = kind[5] && !kind[1];
    if (kind[1]) exp_s = 6'b010111;
    else if (kind[4]) exp_s = w ? 6'b111110 : 6'b111101;
    else exp_s = ~{!w, w, !w & kind[3], w & kind[3], 2'b00};
    do_req(kind, addr, wd);
    for (int i = 0; i < 200 && n_done == n0; i++) @(posedge clk_i);
    chk("cycle ran", n_done == n0 + 1, 1);
    // enable drops two cycles after the strobe
    repeat (3) @(posedge clk_i);
    chk("strobes", strb, exp_s);
    chk("sbhe", sbhe_seen, !kind[0]);
    chk("address at end", sa_end, addr);
    chk("ale to end", t_rise - t_ale >= (kind[2] ? imc_pkg::ADDR_DATA16_CYC :
      imc_pkg::ADDR_DATA8_CYC), 1);
    chk("addr before ready drop", t_fall - t_ale >= (kind[2] ? 4 : 7), 1);
    chk("ready to next ale", ale_gap >= imc_pkg::RDY_NEXT_ALE_T, 1);
    if (waits != 4'h0) begin
      chk("ready to end", t_rise - t_rdy >= (w ? 3 : 2), 1);
    end
    if (w) begin
      chk("write data", wr_seen, (!kind[2] && addr[0]) ? {2{wd[15:8]}} : wd);
      chk("data setup", t_fall - t_oe >= imc_pkg::WDATA_SETUP_CYC, 1);
      chk("data hold", t_oe_off - t_rise >= imc_pkg::WDATA_HOLD_CYC, 1);
    end else if (kind[1]) begin
      chk("no push on refresh", rd_valid_o, 0);
    end else begin
      chk("command width", t_rise - t_fall >= (kind[2] ? imc_pkg::CMD_DATA16_CYC :
        imc_pkg::CMD_DATA8_CYC), 1);
      pop(addr[15:0] ^ 16'h5a5a);
    end
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset();
    chk("outputs in reset",
      {strb_w, sbhe_n_o, ale_o, sd_oe_o, req_ready_o, rd_valid_o}, 11'h7f0);
    $display("test reset done");
  endtask

  // every cycle kind but refresh, both widths, odd narrow addresses exercise the byte copy
  task automatic t_kinds(input logic [3:0] nw);
    logic [2:0] ty;
    waits <= nw;
    for (int i = 0; i < 12; i++) begin
      ty = 3'((i >> 1) % 3);
      run_cyc({i[0], ty == 3'h2, ty == 3'h1, i >= 6, 1'b0, i[0] ^ (i >= 6)},
        20'h0_4c00 + 20'(i), 16'h3c00 + 16'(i * 16'h0111));
    end
    $display("test kinds done");
  endtask

  task automatic t_refresh();
    waits <= 4'h2;
    run_cyc(6'b000110, 20'h0_0012, 16'h0000);
    $display("test refresh done");
  endtask

  // fill the read buffer until requests are refused, then drain it in order
  task automatic t_fill();
    int a0;
    // one wait state so back-to-back cycles also time ready against the next latch
    waits <= 4'h1;
    for (int i = 0; i < 16; i++) do_req(6'b000100, 20'h0_0200 + 20'(i), 16'h0000);
    repeat (30) @(posedge clk_i);
    chk("refused when full", req_ready_o, 0);
    a0 = t_ale;
    req_valid_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    req_valid_i <= 1'b0;
    chk("ignored when full", t_ale == a0, 1);
    for (int i = 0; i < 16; i++) pop(16'h0200 + 16'(i) ^ 16'h5a5a);
    repeat (3) @(posedge clk_i);
    chk("empty after drain", {rd_valid_o, req_ready_o}, 2'b01);
    chk("ready to next ale", ale_gap >= imc_pkg::RDY_NEXT_ALE_T, 1);
    $display("test fill done");
  endtask

  initial begin
    {reset_n_i, req_valid_i, req_write_i, req_io_i, req_low_i, req_wide_i} = 6'h00;
    {req_refresh_i, req_sbhe_i, rd_ready_i} = 3'h0;
    req_addr_i = 20'h0_0000;
    req_wdata_i = 16'h0000;
    waits = 4'h0;
    repeat (2) @(posedge clk_i);
    t_reset();
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_kinds(4'h0);
    t_kinds(4'h3);
    t_refresh();
    t_fill();
    finish_test();
  end
endmodule
